// ==== core/aam_pkg.sv ====
package aam_pkg;

    localparam int NUM_LINES = 4;
    localparam int VAL_W     = 16;
    localparam int ADC_W     = 10;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_INTERVAL = 12'h004;
    localparam logic [11:0] OFS_STATUS   = 12'h008;
    localparam logic [11:0] OFS_EVT_SET  = 12'h00C;
    localparam logic [11:0] OFS_EVT_CLR  = 12'h010;
    localparam logic [11:0] OFS_LINE0    = 12'h100;
    localparam logic [11:0] LINE_STRIDE  = 12'h020;
    // Per-line word indices inside a line block
    localparam logic [2:0]  LW_CONV_ZERO = 3'd0;
    localparam logic [2:0]  LW_CONV_FULL = 3'd1;
    localparam logic [2:0]  LW_CALIB     = 3'd2;
    localparam logic [2:0]  LW_LOW_PT    = 3'd3;
    localparam logic [2:0]  LW_HIGH_PT   = 3'd4;
    localparam logic [2:0]  LW_HYST      = 3'd5;
    localparam logic [2:0]  LW_ENABLE    = 3'd6;
    localparam logic [2:0]  LW_READING   = 3'd7;

    // Field positions
    localparam int SIGN_BIT   = 15;
    localparam int EN_LOW_BIT = 0;
    localparam int EN_HI_BIT  = 1;
    localparam int RES_LSB    = 4;

    localparam logic [31:0] RST_INTERVAL = 32'h0000_0064;
    localparam logic [1:0]  RST_ENABLE   = 2'b11;
    localparam logic [31:0] BAD_DATA     = 32'h0000_0000;

    typedef enum logic [1:0] {
        AAM_IDLE  = 2'b00,
        AAM_CALC  = 2'b01,
        AAM_COMP  = 2'b11
    } aam_state_e;

endpackage

// ==== core/aam_line_if.sv ====
`timescale 1ns/1ns
interface aam_line_if;
    import aam_pkg::*;
    logic [ADC_W-1:0] adc_code;
    logic [VAL_W-1:0] zero_v;
    logic [VAL_W-1:0] full_v;
    logic [VAL_W-1:0] calib_v;
    logic             start;
    logic             done;
    logic [VAL_W-1:0] reading;
    modport master (output adc_code, zero_v, full_v, calib_v, start,
                    input done, reading);
    modport conv (input adc_code, zero_v, full_v, calib_v, start,
                  output done, reading);
endinterface

// ==== core/aam_conv.sv ====
`timescale 1ns/1ns
module aam_conv
    import aam_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Conversion channel
    aam_line_if.conv  lif
);
    logic signed [VAL_W+ADC_W+1:0] prod_reg;
    logic                          stage_reg;
    logic signed [VAL_W:0]         span;
    logic signed [VAL_W+ADC_W+1:0] interp;
    logic signed [VAL_W+1:0]       sum;

    assign span   = $signed({lif.full_v[VAL_W-1], lif.full_v})
                  - $signed({lif.zero_v[VAL_W-1], lif.zero_v});
    assign interp = prod_reg >>> ADC_W;
    assign sum    = $signed(interp[VAL_W+1:0])
                  + $signed({{2{lif.zero_v[VAL_W-1]}}, lif.zero_v})
                  + $signed({{2{lif.calib_v[VAL_W-1]}}, lif.calib_v});

    // ------------------------------------------------------------
    // Two-stage interpolation
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            prod_reg  <= '0;
            stage_reg <= 1'b0;
            lif.done  <= 1'b0;
        end else begin
            prod_reg  <= (VAL_W+ADC_W+2)'(span
                         * $signed({1'b0, lif.adc_code}));
            stage_reg <= lif.start;
            lif.done  <= stage_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lif.reading <= '0;
        end else if (stage_reg) begin
            lif.reading <= sum[VAL_W-1:0];
        end
    end
endmodule

// ==== core/aam_top.sv ====
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
module aam_top
    import aam_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    srst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Analog readings, one converter code per line
    input  wire logic [LINES*ADC_W-1:0]  adc_codes,
    // Alarm events, one bit per line
    output logic      [LINES-1:0]        low_set_evt,
    output logic      [LINES-1:0]        high_set_evt,
    output logic      [LINES-1:0]        low_clr_evt,
    output logic      [LINES-1:0]        high_clr_evt,
    // Alarm state, one bit per line
    output logic      [LINES-1:0]        low_alarm,
    output logic      [LINES-1:0]        high_alarm
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [VAL_W-1:0] zero_reg  [LINES];
    logic [VAL_W-1:0] full_reg  [LINES];
    logic [VAL_W-1:0] calib_reg [LINES];
    logic [VAL_W-1:0] lowp_reg  [LINES];
    logic [VAL_W-1:0] highp_reg [LINES];
    logic [VAL_W-1:0] hyst_reg  [LINES];
    logic [VAL_W-1:0] rd_reg    [LINES];
    logic [1:0]       en_reg    [LINES];
    logic [1:0]       res_reg   [LINES];
    logic [31:0]      interval_reg;
    logic [31:0]      tick_cnt_reg;
    logic             tick_reg;
    logic [LINES-1:0] set_sticky_reg;
    logic [LINES-1:0] clr_sticky_reg;
    logic [LINES*ADC_W-1:0] adc_s1_reg;
    logic [LINES*ADC_W-1:0] adc_s2_reg;
    aam_state_e       state_reg;
    logic [1:0]       idx_reg;
    logic             conv_start_reg;

    aam_line_if lif ();

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            adc_s1_reg <= '0;
            adc_s2_reg <= '0;
        end else begin
            adc_s1_reg <= adc_codes;
            adc_s2_reg <= adc_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic        acc;
    logic        wr;
    logic        in_line;
    logic [11:0] line_ofs;
    logic [2:0]  lw;
    logic [3:0]  ln;
    logic        line_ok;
    logic        top_ok;

    assign acc      = psel && penable && !pready;
    assign wr       = psel && penable && pready && pwrite;
    assign in_line  = paddr >= OFS_LINE0;
    assign line_ofs = paddr - OFS_LINE0;
    assign ln       = line_ofs[8:5];
    assign lw       = line_ofs[4:2];
    assign line_ok  = in_line && (line_ofs[11:9] == 3'b000)
                   && (ln < 4'(LINES)) && (paddr[1:0] == 2'b00);
    assign top_ok   = paddr == OFS_CTRL || paddr == OFS_INTERVAL
                   || paddr == OFS_STATUS || paddr == OFS_EVT_SET
                   || paddr == OFS_EVT_CLR;

    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc && !(line_ok || top_ok);
        end
    end

    // Line configuration writes
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < LINES; i++) begin
                zero_reg[i]  <= '0;
                full_reg[i]  <= '0;
                calib_reg[i] <= '0;
                lowp_reg[i]  <= '0;
                highp_reg[i] <= '0;
                hyst_reg[i]  <= '0;
                en_reg[i]    <= RST_ENABLE;
                res_reg[i]   <= '0;
            end
        end else if (wr && line_ok) begin
            case (lw)
                LW_CONV_ZERO: zero_reg[ln[1:0]]  <= pwdata[VAL_W-1:0];
                LW_CONV_FULL: full_reg[ln[1:0]]  <= pwdata[VAL_W-1:0];
                LW_CALIB:     calib_reg[ln[1:0]] <= pwdata[VAL_W-1:0];
                LW_LOW_PT:    lowp_reg[ln[1:0]]  <= pwdata[VAL_W-1:0];
                LW_HIGH_PT:   highp_reg[ln[1:0]] <= pwdata[VAL_W-1:0];
                LW_HYST:      hyst_reg[ln[1:0]]  <=
                                  {1'b0, pwdata[VAL_W-2:0]};
                LW_ENABLE: begin
                    en_reg[ln[1:0]]  <= pwdata[EN_HI_BIT:EN_LOW_BIT];
                    res_reg[ln[1:0]] <= pwdata[RES_LSB+1:RES_LSB];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            interval_reg <= RST_INTERVAL;
        end else if (wr && paddr == OFS_INTERVAL) begin
            interval_reg <= pwdata;
        end
    end

    // Read mux
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= '0;
        end else if (acc && !pwrite) begin
            prdata <= BAD_DATA;
            if (line_ok) begin
                case (lw)
                    LW_CONV_ZERO: prdata <= 32'(zero_reg[ln[1:0]]);
                    LW_CONV_FULL: prdata <= 32'(full_reg[ln[1:0]]);
                    LW_CALIB:     prdata <= 32'(calib_reg[ln[1:0]]);
                    LW_LOW_PT:    prdata <= 32'(lowp_reg[ln[1:0]]);
                    LW_HIGH_PT:   prdata <= 32'(highp_reg[ln[1:0]]);
                    LW_HYST:      prdata <= 32'(hyst_reg[ln[1:0]]);
                    LW_ENABLE:    prdata <= 32'({res_reg[ln[1:0]], 2'b00,
                                                  en_reg[ln[1:0]]});
                    default:      prdata <= 32'(rd_reg[ln[1:0]]);
                endcase
            end else if (paddr == OFS_INTERVAL) begin
                prdata <= interval_reg;
            end else if (paddr == OFS_STATUS) begin
                prdata <= 32'({high_alarm, low_alarm});
            end else if (paddr == OFS_EVT_SET) begin
                prdata <= 32'(set_sticky_reg);
            end else if (paddr == OFS_EVT_CLR) begin
                prdata <= 32'(clr_sticky_reg);
            end
        end
    end

    // ------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg + 32'd1 >= interval_reg) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'd1;
            tick_reg     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Scan sequencer and converter
    // ------------------------------------------------------------
    assign lif.adc_code = adc_s2_reg[idx_reg*ADC_W +: ADC_W];
    assign lif.zero_v   = zero_reg[idx_reg];
    assign lif.full_v   = full_reg[idx_reg];
    assign lif.calib_v  = calib_reg[idx_reg];
    assign lif.start    = conv_start_reg;

    aam_conv u_conv (
        .clk  (clk),
        .srst (srst),
        .lif  (lif)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg      <= AAM_IDLE;
            idx_reg        <= '0;
            conv_start_reg <= 1'b0;
        end else begin
            conv_start_reg <= 1'b0;
            case (state_reg)
                AAM_IDLE: if (tick_reg) begin
                    idx_reg        <= '0;
                    conv_start_reg <= 1'b1;
                    state_reg      <= AAM_CALC;
                end
                AAM_CALC: if (lif.done) begin
                    state_reg <= AAM_COMP;
                end
                AAM_COMP: begin
                    if (idx_reg == 2'(LINES-1)) begin
                        state_reg <= AAM_IDLE;
                    end else begin
                        idx_reg        <= idx_reg + 2'd1;
                        conv_start_reg <= 1'b1;
                        state_reg      <= AAM_CALC;
                    end
                end
                default: state_reg <= AAM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Comparison per line
    // ------------------------------------------------------------
    function automatic logic signed [VAL_W+1:0] sv(input logic [VAL_W-1:0] v);
        // Sign digit plus magnitude to two's complement
        sv = v[SIGN_BIT] ? -$signed({3'b000, v[VAL_W-2:0]})
                         :  $signed({3'b000, v[VAL_W-2:0]});
    endfunction

    generate
        for (genvar g = 0; g < LINES; g++) begin : g_line
            logic signed [VAL_W+1:0] r;
            logic signed [VAL_W+1:0] lo;
            logic signed [VAL_W+1:0] hi;
            logic signed [VAL_W+1:0] hy;
            logic                    eval;
            assign r    = $signed({{2{lif.reading[VAL_W-1]}}, lif.reading});
            assign lo   = sv(lowp_reg[g]);
            assign hi   = sv(highp_reg[g]);
            assign hy   = $signed({3'b000, hyst_reg[g][VAL_W-2:0]});
            assign eval = state_reg == AAM_COMP && idx_reg == 2'(g);

            always_ff @(posedge clk) begin
                if (srst) begin
                    rd_reg[g]       <= '0;
                    low_alarm[g]    <= 1'b0;
                    high_alarm[g]   <= 1'b0;
                    low_set_evt[g]  <= 1'b0;
                    high_set_evt[g] <= 1'b0;
                    low_clr_evt[g]  <= 1'b0;
                    high_clr_evt[g] <= 1'b0;
                end else begin
                    low_set_evt[g]  <= 1'b0;
                    high_set_evt[g] <= 1'b0;
                    low_clr_evt[g]  <= 1'b0;
                    high_clr_evt[g] <= 1'b0;
                    if (eval) begin
                        rd_reg[g] <= lif.reading;
                        if (!low_alarm[g] && r < lo) begin
                            low_alarm[g]   <= 1'b1;
                            low_set_evt[g] <=
                                en_reg[g][EN_LOW_BIT];
                        end else if (low_alarm[g] && r > lo + hy) begin
                            low_alarm[g]   <= 1'b0;
                            low_clr_evt[g] <= 1'b1;
                        end
                        if (!high_alarm[g] && r > hi) begin
                            high_alarm[g]   <= 1'b1;
                            high_set_evt[g] <=
                                en_reg[g][EN_HI_BIT];
                        end else if (high_alarm[g] && r < hi - hy) begin
                            high_alarm[g]   <= 1'b0;
                            high_clr_evt[g] <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // Sticky event record, set wins over a write-one-to-clear write
    always_ff @(posedge clk) begin
        if (srst) begin
            set_sticky_reg <= '0;
            clr_sticky_reg <= '0;
        end else begin
            set_sticky_reg <= ((wr && paddr == OFS_EVT_SET)
                               ? set_sticky_reg & ~pwdata[LINES-1:0]
                               : set_sticky_reg)
                              | low_set_evt | high_set_evt;
            clr_sticky_reg <= ((wr && paddr == OFS_EVT_CLR)
                               ? clr_sticky_reg & ~pwdata[LINES-1:0]
                               : clr_sticky_reg)
                              | low_clr_evt | high_clr_evt;
        end
    end
endmodule

// ==== testbench/aam_sensor.sv ====
`timescale 1ns/1ns
module aam_sensor
    import aam_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // Analog level per line
    input  wire logic [LINES*ADC_W-1:0] level,
    // Converter codes to the monitor
    output logic      [LINES*ADC_W-1:0] adc_codes
);
    // Code tracks the level linearly, one sample late
    always_ff @(posedge clk) begin
        if (srst) begin
            adc_codes <= '0;
        end else begin
            adc_codes <= level;
        end
    end
endmodule

// ==== testbench/aam_top_chk.sv ====
`timescale 1ns/1ns
module aam_top_chk
    import aam_pkg::*;
#(
    parameter int LINES = NUM_LINES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // APB
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pready,
    input  wire logic             pslverr,
    // Alarms
    input  wire logic [LINES-1:0] low_set_evt,
    input  wire logic [LINES-1:0] high_set_evt,
    input  wire logic [LINES-1:0] low_clr_evt,
    input  wire logic [LINES-1:0] high_clr_evt,
    input  wire logic [LINES-1:0] low_alarm,
    input  wire logic [LINES-1:0] high_alarm
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_low_set_edge: assert property (
        (low_set_evt & ~(low_alarm & ~$past(low_alarm))) == '0)
        else $error("Low set event without alarm entry");
    a_high_set_edge: assert property (
        (high_set_evt & ~(high_alarm & ~$past(high_alarm))) == '0)
        else $error("High set event without alarm entry");
    a_low_clr_edge: assert property (
        low_clr_evt == ($past(low_alarm) & ~low_alarm))
        else $error("Low clear event does not match alarm exit");
    a_high_clr_edge: assert property (
        high_clr_evt == ($past(high_alarm) & ~high_alarm))
        else $error("High clear event does not match alarm exit");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("Ready held longer than one cycle");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("Ready not given after one wait state");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("Ready without access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("Error flag without ready");

    c_low_set: cover property (|low_set_evt);
    c_high_clr: cover property (|high_clr_evt);
    c_err: cover property (pslverr);
endmodule

bind aam_top aam_top_chk #(.LINES(LINES)) u_chk (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .low_set_evt(low_set_evt),
    .high_set_evt(high_set_evt), .low_clr_evt(low_clr_evt),
    .high_clr_evt(high_clr_evt), .low_alarm(low_alarm),
    .high_alarm(high_alarm)
);

// ==== testbench/tb_analog_alarm_monitor.sv ====
`timescale 1ns/1ns
module tb_analog_alarm_monitor
    import aam_pkg::*;
;
    localparam int LN    = 4;
    localparam int LIMIT = 20000;
    typedef struct {
        int          ln;
        logic [15:0] zero, full, calib;
        logic [9:0]  code;
        logic [15:0] lo, hi;
        logic        xl, xh;
    } aam_row_s;

    logic                      clk = 1'b0;
    logic                      srst = 1'b1;
    logic                      psel = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite = 1'b0;
    logic [11:0]               paddr = '0;
    logic [31:0]               pwdata = '0;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [LN-1:0][ADC_W-1:0]  codes = '0;
    logic [LN*ADC_W-1:0]       adc_codes;
    logic [LN-1:0]             lse, hse, lce, hce, la_o, ha_o;
    int                        ls[LN], hs[LN], lc[LN], hc[LN];
    int                        bad_count = 0;
    int                        checked = 0;
    int                        cyc = 0;
    aam_row_s                  rows[6];

    always #4 clk = ~clk;

    aam_sensor #(.LINES(LN)) u_sensor (.clk(clk), .srst(srst),
        .level(codes), .adc_codes(adc_codes));
    aam_top #(.LINES(LN)) dut (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_codes(adc_codes), .low_set_evt(lse),
        .high_set_evt(hse), .low_clr_evt(lce), .high_clr_evt(hce),
        .low_alarm(la_o), .high_alarm(ha_o));

    // Event counters per line
    always @(negedge clk) begin
        for (int i = 0; i < LN; i++) begin
            if (!srst && lse[i] === 1'b1) ls[i]++;
            if (!srst && hse[i] === 1'b1) hs[i]++;
            if (!srst && lce[i] === 1'b1) lc[i]++;
            if (!srst && hce[i] === 1'b1) hc[i]++;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("Checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) bad_count++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
    endtask

    function automatic logic [11:0] lad(input int ln, input logic [2:0] k);
        return OFS_LINE0 + LINE_STRIDE * ln[11:0] + {7'h00, k, 2'b00};
    endfunction

    task automatic setc(input int ln, input logic [9:0] c);
        @(posedge clk);
        codes[ln] <= c;
        repeat (60) @(posedge clk);
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic        e;
        logic [3:0]  xl, xh;
        int          x, b, n;
        aam_row_s    r;
        xl = '0;
        xh = '0;
        rows[0] = '{0, 16'h0000, 16'h0400, 16'h0000, 10'h010,
                    16'h0020, 16'h0100, 1'b1, 1'b0};
        rows[1] = '{1, 16'h0000, 16'h0400, 16'h0000, 10'h200,
                    16'h0020, 16'h0100, 1'b0, 1'b1};
        rows[2] = '{2, 16'h0000, 16'h0400, 16'h0000, 10'h050,
                    16'h0020, 16'h0100, 1'b0, 1'b0};
        rows[3] = '{3, 16'h0000, 16'h0400, 16'h0100, 10'h005,
                    16'h0020, 16'h0100, 1'b0, 1'b1};
        rows[4] = '{2, 16'h0000, 16'h0400, 16'hFFF0, 10'h000,
                    16'h8008, 16'h0100, 1'b1, 1'b0};
        rows[5] = '{0, 16'h0100, 16'h0500, 16'h0000, 10'h010,
                    16'h0020, 16'h0200, 1'b0, 1'b0};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        cmp_word({24'h0, ha_o, la_o}, 32'h0000_0000);
        rd(OFS_INTERVAL, q);
        cmp_word(q, RST_INTERVAL);
        rd(lad(0, LW_ENABLE), q);
        cmp_word(q, {30'h0, RST_ENABLE});
        apb(1'b0, 12'h040, 32'h0000_0000, q, e);
        cmp_bit(e, 1'b1);
        cmp_word(q, BAD_DATA);
        wr(lad(0, LW_HYST), 32'h0000_FFFF);
        rd(lad(0, LW_HYST), q);
        cmp_word(q, 32'h0000_7FFF);
        wr(lad(0, LW_ENABLE), 32'h0000_0023);
        rd(lad(0, LW_ENABLE), q);
        cmp_word(q, 32'h0000_0023);
        wr(OFS_INTERVAL, 32'h0000_0008);
        $display("Reset test done");
        for (int i = 0; i < 6; i++) begin
            r = rows[i];
            wr(lad(r.ln, LW_CONV_ZERO), {16'h0, r.zero});
            wr(lad(r.ln, LW_CONV_FULL), {16'h0, r.full});
            wr(lad(r.ln, LW_CALIB), {16'h0, r.calib});
            wr(lad(r.ln, LW_LOW_PT), {16'h0, r.lo});
            wr(lad(r.ln, LW_HIGH_PT), {16'h0, r.hi});
            wr(lad(r.ln, LW_HYST), 32'h0000_0000);
            wr(lad(r.ln, LW_ENABLE), 32'h0000_0003);
            setc(r.ln, r.code);
            x = int'($signed(r.zero)) + int'($signed(r.calib)) +
                ((int'(r.full) - int'(r.zero)) * int'(r.code)) / 1024;
            rd(lad(r.ln, LW_READING), q);
            cmp_word({16'h0, q[15:0]}, {16'h0, x[15:0]});
            rd(lad(r.ln, LW_LOW_PT), q);
            cmp_word(q, {16'h0, r.lo});
            @(negedge clk);
            cmp_bit(la_o[r.ln], r.xl);
            cmp_bit(ha_o[r.ln], r.xh);
            xl[r.ln] = r.xl;
            xh[r.ln] = r.xh;
            $display("Row %0d done", i);
        end
        rd(OFS_STATUS, q);
        cmp_word(q, {24'h0, xh, xl});
        wr(lad(1, LW_HYST), 32'h0000_0010);
        b = hc[1];
        n = ls[1];
        setc(1, 10'h0F0);
        cmp_bit(ha_o[1], 1'b1);
        setc(1, 10'h0EF);
        cmp_bit(ha_o[1], 1'b0);
        cmp_word(hc[1] - b, 1);
        setc(1, 10'h010);
        setc(1, 10'h030);
        cmp_bit(la_o[1], 1'b1);
        setc(1, 10'h031);
        cmp_bit(la_o[1], 1'b0);
        cmp_word(ls[1] - n, 1);
        $display("Hysteresis test done");
        setc(2, 10'h050);
        wr(lad(2, LW_ENABLE), 32'h0000_0002);
        n = ls[2];
        setc(2, 10'h000);
        cmp_bit(la_o[2], 1'b1);
        cmp_word(ls[2] - n, 0);
        wr(lad(2, LW_ENABLE), 32'h0000_0001);
        rd(lad(2, LW_ENABLE), q);
        cmp_word(q, 32'h0000_0001);
        b = hs[2];
        n = lc[2];
        setc(2, 10'h3FF);
        cmp_bit(ha_o[2], 1'b1);
        cmp_word(hs[2] - b, 0);
        cmp_word(lc[2] - n, 1);
        $display("Enable test done");
        wr(OFS_EVT_SET, 32'h0000_000F);
        wr(OFS_EVT_CLR, 32'h0000_000F);
        setc(1, 10'h000);
        rd(OFS_EVT_SET, q);
        cmp_word(q, 32'h0000_0002);
        rd(OFS_EVT_CLR, q);
        cmp_word(q, 32'h0000_0000);
        rd(OFS_CTRL, q);
        cmp_word(q, 32'h0000_0000);
        $display("Sticky test done");
        wr(OFS_INTERVAL, 32'h0000_00C8);
        @(posedge clk);
        codes[0] <= 10'h3FF;
        n = 0;
        while (ha_o[0] !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        codes[0] <= 10'h000;
        repeat (100) @(posedge clk);
        @(negedge clk);
        cmp_bit(ha_o[0], 1'b1);
        repeat (200) @(posedge clk);
        @(negedge clk);
        cmp_bit(ha_o[0], 1'b0);
        $display("Interval test done");
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        cmp_word({24'h0, ha_o, la_o}, 32'h0000_0000);
        rd(lad(3, LW_HIGH_PT), q);
        cmp_word(q, 32'h0000_0000);
        rd(OFS_INTERVAL, q);
        cmp_word(q, RST_INTERVAL);
        $display("Reset rerun test done");
        conclude();
    end
endmodule
